// file: logic/pec_defines.vh
// constants for the phy extension counter and control bank
`ifndef PEC_DEFINES_VH
`define PEC_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PEC_IDX_FC_CNT     6'h14
`define PEC_IDX_LD_CNT     6'h15
`define PEC_IDX_TEN_CTL    6'h16
`define PEC_IDX_EXT_CTL1   6'h17
`define PEC_IDX_EXT_CTL2   6'h18
`define PEC_IDX_INT_STAT   6'h20
`define PEC_IDX_INT_MASK   6'h21

// ----------------------------------------------------------------
// counter limits
// ----------------------------------------------------------------
`define PEC_CNT_MAX        8'hff
`define PEC_CNT_ZERO       8'h00
`define PEC_CNT_ONE        8'h01

// ----------------------------------------------------------------
// 10 Mb extended control and status fields
// ----------------------------------------------------------------
`define PEC_TEN_LI_DIS     15
`define PEC_TEN_JAB_DIS    14
`define PEC_TEN_ECHO_DIS   13
`define PEC_TEN_SQE_DIS    12
`define PEC_TEN_SQL_HI     11
`define PEC_TEN_SQL_LO     10
`define PEC_TEN_STICKY     9
`define PEC_TEN_EOF_ERR    8
`define PEC_TEN_DISC       7
`define PEC_TEN_LINK       6
`define PEC_TEN_CRS_HI     2
`define PEC_TEN_CRS_LO     1
`define PEC_TEN_WMASK      16'hfe06
`define PEC_TEN_RST        16'h3200

// carrier-sense derivation codes
`define PEC_CRS_RX_OR_HTX  2'h0
`define PEC_CRS_ANY_HDX    2'h1
`define PEC_CRS_RX_ONLY    2'h2
`define PEC_CRS_RX_HDX     2'h3

// ----------------------------------------------------------------
// extended control 1 and 2 fields
// ----------------------------------------------------------------
`define PEC_EXT1_FE_LB     3
`define PEC_EXT1_WMASK     16'h0008
`define PEC_EXT1_RST       16'h0000
`define PEC_EXT2_EDGE_HI   15
`define PEC_EXT2_EDGE_LO   13
`define PEC_EXT2_JUMBO_HI  5
`define PEC_EXT2_JUMBO_LO  4
`define PEC_EXT2_CABLE_LB  0
`define PEC_EXT2_WMASK     16'he031
`define PEC_EXT2_RST       16'h0000

// jumbo codes and packet lengths in bytes
`define PEC_JUMBO_STD      2'h0
`define PEC_JUMBO_9K       2'h1
`define PEC_JUMBO_12K      2'h2
`define PEC_LEN_STD        14'h05ee
`define PEC_LEN_9K         14'h2328
`define PEC_LEN_12K        14'h2ee0

// ----------------------------------------------------------------
// interrupt status and mask layout
// ----------------------------------------------------------------
`define PEC_INT_W          4
`define PEC_INT_FC         0
`define PEC_INT_LD         1
`define PEC_INT_EOF        2
`define PEC_INT_DISC       3
`define PEC_INT_RST        4'h0

`endif

// file: logic/pec_sat_cnt.v
// saturating 8-bit event counter that clears when read
`timescale 1ns/100ps

module pec_sat_cnt (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // event and clear strobes
  input  wire       inc_i,
  input  wire       clr_i,
  // count value
  output reg  [7:0] cnt_o
);

`include "pec_defines.vh"

  // an event landing on the clearing read is kept as a count of one
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o <= `PEC_CNT_ZERO;
    end else if (clr_i) begin
      cnt_o <= inc_i ? `PEC_CNT_ONE : `PEC_CNT_ZERO;
    end else if (inc_i && (cnt_o != `PEC_CNT_MAX)) begin
      cnt_o <= cnt_o + `PEC_CNT_ONE;
    end
  end

endmodule

// file: logic/pec_top.v
// phy extension register bank: event counters, 10 Mb control, loopback and edge rate
`timescale 1ns/100ps

module pec_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // link and event inputs from the phy core
  input  wire        fc_evt_100_i,
  input  wire        fc_evt_1000_i,
  input  wire        link_up_100_i,
  input  wire        link_up_1000_i,
  input  wire        copper_link_i,
  input  wire        ten_eof_err_i,
  input  wire        ten_disc_i,
  input  wire        ten_link_i,
  // carrier-sense inputs
  input  wire        rx_active_i,
  input  wire        tx_active_i,
  input  wire        full_duplex_flag_i,
  // 10 Mb controls
  output reg         ten_li_dis_o,
  output reg         ten_jab_dis_o,
  output reg         ten_echo_dis_o,
  output reg         ten_sqe_dis_o,
  output reg  [1:0]  ten_squelch_o,
  output reg         ten_sticky_o,
  output reg         crs_o,
  // loopback, edge rate and packet length controls
  output reg         far_end_lb_o,
  output reg         cable_lb_o,
  output reg  [2:0]  edge_rate_o,
  output reg  [1:0]  jumbo_sel_o,
  output reg  [13:0] max_pkt_len_o,
  // interrupt
  output reg         irq_o
);

`include "pec_defines.vh"

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // true when the word address selects the given register index
  function hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      hit = (adr[7:2] == idx);
    end
  endfunction

  // byte-lane merge of write data into the low half of a register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wdat;
    input [3:0]  sel;
    begin
      merge16 = old;
      if (sel[0]) begin
        merge16[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
        merge16[15:8] = wdat[15:8];
      end
    end
  endfunction

  // packet length limit for a jumbo code; reserved code keeps the standard limit
  function [13:0] pkt_len;
    input [1:0] code;
    begin
      case (code)
        `PEC_JUMBO_STD: pkt_len = `PEC_LEN_STD;
        `PEC_JUMBO_9K:  pkt_len = `PEC_LEN_9K;
        `PEC_JUMBO_12K: pkt_len = `PEC_LEN_12K;
        default:        pkt_len = `PEC_LEN_STD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------

  wire        take;
  wire        wr;
  wire        rd;
  reg         ack_r;
  reg  [15:0] ten_ctl_r;
  reg  [15:0] ten_ctl_nxt;
  reg  [15:0] ext1_r;
  reg  [15:0] ext1_nxt;
  reg  [15:0] ext2_r;
  reg  [15:0] ext2_nxt;
  reg         eof_flag_r;
  reg         disc_flag_r;
  reg         link_d_r;
  reg  [3:0]  int_stat_r;
  reg  [3:0]  int_stat_nxt;
  reg  [3:0]  int_mask_r;
  reg  [3:0]  int_mask_nxt;
  reg  [15:0] rdata_nxt;
  wire [7:0]  fc_cnt;
  wire [7:0]  ld_cnt;
  wire        fc_inc;
  wire        ld_inc;
  wire        rd_fc;
  wire        rd_ld;
  wire        rd_ten;
  wire [3:0]  int_evt;

  // a request is taken once; ack_r blocks the repeat cycle while ack is high
  assign take = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr   = take & wb_we_i;
  assign rd   = take & ~wb_we_i;

  // one wait-free answer: ack follows the taking edge and drops one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      ack_r    <= take;
      wb_ack_o <= take;
    end
  end

  // ----------------------------------------------------------------
  // event counters
  // ----------------------------------------------------------------

  // false carriers only count at a speed whose link is up
  assign fc_inc = (fc_evt_100_i & link_up_100_i) | (fc_evt_1000_i & link_up_1000_i);
  // a falling copper link is one drop, whatever the speed
  assign ld_inc = link_d_r & ~copper_link_i;

  assign rd_fc  = rd & hit(wb_adr_i, `PEC_IDX_FC_CNT);
  assign rd_ld  = rd & hit(wb_adr_i, `PEC_IDX_LD_CNT);
  assign rd_ten = rd & hit(wb_adr_i, `PEC_IDX_TEN_CTL);

  // previous copper link level for drop detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      link_d_r <= 1'b0;
    end else begin
      link_d_r <= copper_link_i;
    end
  end

  // the counters share one structure; the read that returns a value clears it
  pec_sat_cnt u_fc_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .inc_i (fc_inc),
    .clr_i (rd_fc),
    .cnt_o (fc_cnt)
  );

  pec_sat_cnt u_ld_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .inc_i (ld_inc),
    .clr_i (rd_ld),
    .cnt_o (ld_cnt)
  );

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------

  // reserved positions are masked off so they never hold a written one
  always @* begin
    ten_ctl_nxt = ten_ctl_r;
    ext1_nxt    = ext1_r;
    ext2_nxt    = ext2_r;
    if (wr && hit(wb_adr_i, `PEC_IDX_TEN_CTL)) begin
      ten_ctl_nxt = merge16(ten_ctl_r, wb_dat_i, wb_sel_i) & `PEC_TEN_WMASK;
    end
    if (wr && hit(wb_adr_i, `PEC_IDX_EXT_CTL1)) begin
      ext1_nxt = merge16(ext1_r, wb_dat_i, wb_sel_i) & `PEC_EXT1_WMASK;
    end
    if (wr && hit(wb_adr_i, `PEC_IDX_EXT_CTL2)) begin
      ext2_nxt = merge16(ext2_r, wb_dat_i, wb_sel_i) & `PEC_EXT2_WMASK;
    end
  end

  // reset values leave echo mode and the quality test disabled
  always @(posedge clk_i) begin
    if (rst_i) begin
      ten_ctl_r <= `PEC_TEN_RST;
      ext1_r    <= `PEC_EXT1_RST;
      ext2_r    <= `PEC_EXT2_RST;
    end else begin
      ten_ctl_r <= ten_ctl_nxt;
      ext1_r    <= ext1_nxt;
      ext2_r    <= ext2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // sticky 10 Mb flags
  // ----------------------------------------------------------------

  // a flag set in the same cycle as its clearing read stays set
  always @(posedge clk_i) begin
    if (rst_i) begin
      eof_flag_r  <= 1'b0;
      disc_flag_r <= 1'b0;
    end else begin
      eof_flag_r  <= ten_eof_err_i | (eof_flag_r & ~rd_ten);
      disc_flag_r <= ten_disc_i | (disc_flag_r & ~rd_ten);
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------

  // outputs follow the register flops one edge later so that all come from flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      ten_li_dis_o   <= 1'b0;
      ten_jab_dis_o  <= 1'b0;
      ten_echo_dis_o <= 1'b1;
      ten_sqe_dis_o  <= 1'b1;
      ten_squelch_o  <= 2'h0;
      ten_sticky_o   <= 1'b1;
      far_end_lb_o   <= 1'b0;
      cable_lb_o     <= 1'b0;
      edge_rate_o    <= 3'h0;
      jumbo_sel_o    <= 2'h0;
      max_pkt_len_o  <= `PEC_LEN_STD;
    end else begin
      ten_li_dis_o   <= ten_ctl_r[`PEC_TEN_LI_DIS];
      ten_jab_dis_o  <= ten_ctl_r[`PEC_TEN_JAB_DIS];
      ten_echo_dis_o <= ten_ctl_r[`PEC_TEN_ECHO_DIS];
      ten_sqe_dis_o  <= ten_ctl_r[`PEC_TEN_SQE_DIS];
      ten_squelch_o  <= ten_ctl_r[`PEC_TEN_SQL_HI:`PEC_TEN_SQL_LO];
      ten_sticky_o   <= ten_ctl_r[`PEC_TEN_STICKY];
      far_end_lb_o   <= ext1_r[`PEC_EXT1_FE_LB];
      cable_lb_o     <= ext2_r[`PEC_EXT2_CABLE_LB];
      edge_rate_o    <= ext2_r[`PEC_EXT2_EDGE_HI:`PEC_EXT2_EDGE_LO];
      jumbo_sel_o    <= ext2_r[`PEC_EXT2_JUMBO_HI:`PEC_EXT2_JUMBO_LO];
      max_pkt_len_o  <= pkt_len(ext2_r[`PEC_EXT2_JUMBO_HI:`PEC_EXT2_JUMBO_LO]);
    end
  end

  // carrier sense is registered; it lags its inputs by one clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      crs_o <= 1'b0;
    end else begin
      case (ten_ctl_r[`PEC_TEN_CRS_HI:`PEC_TEN_CRS_LO])
        `PEC_CRS_RX_OR_HTX: crs_o <= rx_active_i | (tx_active_i & ~full_duplex_flag_i);
        `PEC_CRS_ANY_HDX:   crs_o <= (rx_active_i | tx_active_i) & ~full_duplex_flag_i;
        `PEC_CRS_RX_ONLY:   crs_o <= rx_active_i;
        `PEC_CRS_RX_HDX:    crs_o <= rx_active_i & ~full_duplex_flag_i;
        default:            crs_o <= rx_active_i;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------

  assign int_evt[`PEC_INT_FC]   = fc_inc;
  assign int_evt[`PEC_INT_LD]   = ld_inc;
  assign int_evt[`PEC_INT_EOF]  = ten_eof_err_i;
  assign int_evt[`PEC_INT_DISC] = ten_disc_i;

  // write-one-to-clear, with a new event winning over its clear
  always @* begin
    int_stat_nxt = int_stat_r;
    int_mask_nxt = int_mask_r;
    if (wr && hit(wb_adr_i, `PEC_IDX_INT_STAT) && wb_sel_i[0]) begin
      int_stat_nxt = int_stat_r & ~wb_dat_i[`PEC_INT_W-1:0];
    end
    if (wr && hit(wb_adr_i, `PEC_IDX_INT_MASK) && wb_sel_i[0]) begin
      int_mask_nxt = wb_dat_i[`PEC_INT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | int_evt;
  end

  // irq is a level that trails the status and mask flops by one clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= `PEC_INT_RST;
      int_mask_r <= `PEC_INT_RST;
      irq_o      <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      irq_o      <= |(int_stat_r & int_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // unmapped indices and reserved bits read as zero
  always @* begin
    rdata_nxt = 16'h0000;
    if (hit(wb_adr_i, `PEC_IDX_FC_CNT)) begin
      rdata_nxt = {8'h00, fc_cnt};
    end else if (hit(wb_adr_i, `PEC_IDX_LD_CNT)) begin
      rdata_nxt = {8'h00, ld_cnt};
    end else if (hit(wb_adr_i, `PEC_IDX_TEN_CTL)) begin
      rdata_nxt = ten_ctl_r & `PEC_TEN_WMASK;
      rdata_nxt[`PEC_TEN_EOF_ERR] = eof_flag_r;
      rdata_nxt[`PEC_TEN_DISC]    = disc_flag_r;
      rdata_nxt[`PEC_TEN_LINK]    = ten_link_i;
    end else if (hit(wb_adr_i, `PEC_IDX_EXT_CTL1)) begin
      rdata_nxt = ext1_r & `PEC_EXT1_WMASK;
    end else if (hit(wb_adr_i, `PEC_IDX_EXT_CTL2)) begin
      rdata_nxt = ext2_r & `PEC_EXT2_WMASK;
    end else if (hit(wb_adr_i, `PEC_IDX_INT_STAT)) begin
      rdata_nxt = {12'h000, int_stat_r};
    end else if (hit(wb_adr_i, `PEC_IDX_INT_MASK)) begin
      rdata_nxt = {12'h000, int_mask_r};
    end
  end

  // data is captured at the taking edge, the same edge that clears on read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {16'h0000, rdata_nxt};
    end
  end

endmodule

// file: bench/pec_top_properties.sv
// assertion checker for the phy extension register bank ports
`timescale 1ns/100ps

module pec_top_props (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // register bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // phy side
  input wire        rx_active_i,
  input wire        tx_active_i,
  input wire        full_duplex_flag_i,
  input wire        ten_link_i,
  input wire        crs_o,
  input wire        ten_li_dis_o,
  input wire        far_end_lb_o,
  input wire        cable_lb_o,
  input wire [2:0]  edge_rate_o,
  input wire [1:0]  jumbo_sel_o,
  input wire [13:0] max_pkt_len_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bits that may read as one; unmapped places read all zero
  function [15:0] rmask(input [7:0] a);
    case (a[7:2])
      6'h14, 6'h15: rmask = 16'h00ff;
      6'h16: rmask = 16'hffc6;
      6'h17: rmask = 16'h0008;
      6'h18: rmask = 16'he031;
      6'h20, 6'h21: rmask = 16'h000f;
      default: rmask = 16'h0000;
    endcase
  endfunction

  // acknowledged writes per register, still held by the master at ack
  wire wr_ten = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h16;
  wire wr_one = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h17;
  wire wr_two = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h18;
  wire rd_ack = wb_ack_o && !wb_we_i;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_reserved_zero: assert property (
    rd_ack |-> (wb_dat_o & ~{16'h0000, rmask(wb_adr_i)}) == 32'h0)
    else $error("reserved read bit not zero");
  a_link_live: assert property (
    rd_ack && wb_adr_i[7:2] == 6'h16 |-> wb_dat_o[6] == $past(ten_link_i))
    else $error("link bit not live");
  a_ten_ctl_write: assert property ($changed(ten_li_dis_o) |-> $past(wr_ten))
    else $error("10 Mb control moved without a write");
  a_far_lb_write: assert property ($changed(far_end_lb_o) |-> $past(wr_one))
    else $error("far-end loopback moved without a write");
  a_ctl_two_write: assert property (
    $changed({edge_rate_o, jumbo_sel_o, cable_lb_o}) |-> $past(wr_two))
    else $error("control 2 outputs moved without a write");
  a_jumbo_len: assert property (max_pkt_len_o == (jumbo_sel_o == 2'h1 ? 14'h2328 :
    jumbo_sel_o == 2'h2 ? 14'h2ee0 : 14'h05ee))
    else $error("packet length does not follow jumbo code");
  a_crs_rx_hdx: assert property (
    !$past(rst_i) && $past(rx_active_i && !full_duplex_flag_i) |-> crs_o)
    else $error("carrier sense low while receiving half duplex");
  a_crs_idle: assert property (
    !$past(rst_i) && $past(!rx_active_i && (!tx_active_i || full_duplex_flag_i)) |-> !crs_o)
    else $error("carrier sense high with no cause");
endmodule

// file: bench/pec_top_tb.sv
// self-checking testbench for the phy extension register bank
`timescale 1ns/100ps
`include "pec_defines.vh"

module pec_top_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i;
  reg         fc_evt_100_i, fc_evt_1000_i, link_up_100_i, link_up_1000_i, copper_link_i;
  reg         ten_eof_err_i, ten_disc_i, ten_link_i, rx_active_i, tx_active_i, full_duplex_flag_i;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, ten_li_dis_o, ten_jab_dis_o, ten_echo_dis_o, ten_sqe_dis_o;
  wire        ten_sticky_o, crs_o, far_end_lb_o, cable_lb_o, irq_o;
  wire [1:0]  ten_squelch_o, jumbo_sel_o;
  wire [2:0]  edge_rate_o;
  wire [13:0] max_pkt_len_o;
  integer     miscompares, cmp_count, i, j, m;
  reg  [31:0] q;
  reg         e;
  reg  [3:0]  s;
  // all register-driven control outputs in one word so one compare covers them
  wire [31:0] ctl = {4'h0, ten_li_dis_o, ten_jab_dis_o, ten_echo_dis_o, ten_sqe_dis_o, ten_squelch_o,
                     ten_sticky_o, far_end_lb_o, cable_lb_o, edge_rate_o, jumbo_sel_o, max_pkt_len_o};

  pec_top u_pec_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .fc_evt_100_i, .fc_evt_1000_i, .link_up_100_i, .link_up_1000_i,
    .copper_link_i, .ten_eof_err_i, .ten_disc_i, .ten_link_i, .rx_active_i, .tx_active_i,
    .full_duplex_flag_i, .ten_li_dis_o, .ten_jab_dis_o, .ten_echo_dis_o, .ten_sqe_dis_o,
    .ten_squelch_o, .ten_sticky_o, .crs_o, .far_end_lb_o, .cable_lb_o, .edge_rate_o, .jumbo_sel_o,
    .max_pkt_len_o, .irq_o);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task complete_run;
    begin
      if (miscompares == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] x);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask

  // one classic cycle; ack and read data are taken at the same edge
  task bus(input w, input [7:0] a, input [15:0] d);
    integer n;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {16'h0000, d};
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n == 50)
        miscompares = miscompares + 1;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask

  task rc(input [7:0] a, input [31:0] x);
    begin
      bus(1'b0, a, 16'h0000);
      chk(q, x);
    end
  endtask

  // outputs are looked at mid-cycle, after a full edge has landed
  task see;
    begin
      @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask

  function [31:0] ex(input [15:0] a, input [15:0] b, input [15:0] c);
    reg [13:0] len;
    begin
      len = c[5:4] == 2'h1 ? 14'h2328 : c[5:4] == 2'h2 ? 14'h2ee0 : 14'h05ee;
      ex = {4'h0, a[15:9], b[3], c[0], c[15:13], c[5:4], len};
    end
  endfunction

  // write all three control registers, read them back, check the outputs
  task cfg(input [15:0] a, input [15:0] b, input [15:0] c);
    begin
      bus(1'b1, 8'h58, a);
      bus(1'b1, 8'h5c, b);
      bus(1'b1, 8'h60, c);
      rc(8'h58, a & `PEC_TEN_WMASK);
      rc(8'h5c, b & `PEC_EXT1_WMASK);
      rc(8'h60, c & `PEC_EXT2_WMASK);
      see;
      chk(ctl, ex(a, b, c));
    end
  endtask

  // k picks one event line; k = 4 makes one copper link drop
  task pulse(input integer k, input integer n);
    begin
      repeat (n) begin
        @(posedge clk_i);
        {fc_evt_100_i, fc_evt_1000_i, ten_eof_err_i, ten_disc_i, copper_link_i} <= 5'h10 >> k;
        @(posedge clk_i);
        {fc_evt_100_i, fc_evt_1000_i, ten_eof_err_i, ten_disc_i, copper_link_i} <= 5'h00;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // the tests need about 1600 cycles; this allows 30000, nearly twenty times that
  initial begin
    #3000000;
    miscompares = miscompares + 1;
    complete_run;
  end

  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 47'h0;
    s = 4'h3;
    {fc_evt_100_i, fc_evt_1000_i, link_up_100_i, link_up_1000_i, copper_link_i} = 5'h00;
    {ten_eof_err_i, ten_disc_i, ten_link_i, rx_active_i, tx_active_i, full_duplex_flag_i} = 6'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h50, 32'h0);
    rc(8'h54, 32'h0);
    rc(8'h58, 32'h3200);
    see;
    chk(ctl, ex(16'h3200, 16'h0000, 16'h0000));
    cfg(16'hffff, 16'hffff, 16'hffff);
    for (i = 0; i < 8; i = i + 1)
      cfg({i[2:0], i[0], i[1:0], i[2], 6'h00, i[1:0], 1'b0}, {12'h000, i[0], 3'h0},
          {i[2:0], 7'h00, i[1:0], 3'h0, i[0]});
    // every carrier-sense code against every input combination
    for (m = 0; m < 4; m = m + 1) begin
      bus(1'b1, 8'h58, m[1:0] << 1);
      for (j = 0; j < 8; j = j + 1) begin
        @(posedge clk_i);
        {rx_active_i, tx_active_i, full_duplex_flag_i} <= j[2:0];
        see;
        case (m)
          0: e = j[2] | (j[1] & ~j[0]);
          1: e = (j[2] | j[1]) & ~j[0];
          2: e = j[2];
          default: e = j[2] & ~j[0];
        endcase
        chk(crs_o, e);
      end
    end
    cfg(16'h3200, 16'h0000, 16'h0000);
    // false carriers count only while the matching link is up
    @(posedge clk_i);
    link_up_100_i <= 1'b1;
    pulse(0, 3);
    pulse(1, 2);
    link_up_1000_i <= 1'b1;
    pulse(1, 1);
    rc(8'h50, 32'h4);
    rc(8'h50, 32'h0);
    pulse(1, 300);
    rc(8'h50, 32'hff);
    bus(1'b1, 8'h50, 16'h00aa);
    rc(8'h50, 32'h0);
    pulse(4, 5);
    rc(8'h54, 32'h5);
    pulse(4, 260);
    rc(8'h54, 32'hff);
    rc(8'h54, 32'h0);
    // sticky 10 Mb flags clear on read, link bit stays live
    ten_link_i <= 1'b1;
    pulse(2, 1);
    pulse(3, 1);
    rc(8'h58, 32'h33c0);
    rc(8'h58, 32'h3240);
    // interrupt status, mask and level output
    rc(8'h80, 32'hf);
    see;
    chk(irq_o, 1'b0);
    bus(1'b1, 8'h84, 16'h0002);
    see;
    chk(irq_o, 1'b1);
    bus(1'b1, 8'h80, 16'h0001);
    rc(8'h80, 32'he);
    bus(1'b1, 8'h80, 16'h0002);
    see;
    chk(irq_o, 1'b0);
    pulse(4, 1);
    // the drop is seen the cycle after the link falls, irq trails the status by one more
    see;
    see;
    chk(irq_o, 1'b1);
    rc(8'h54, 32'h1);
    // only the selected byte lane of a write lands
    s = 4'h2;
    bus(1'b1, 8'h60, 16'hffff);
    rc(8'h60, 32'he000);
    s = 4'h3;
    // unmapped place ignores writes and reads zero
    bus(1'b1, 8'h40, 16'hffff);
    rc(8'h40, 32'h0);
    complete_run;
  end
endmodule

bind pec_top pec_top_props u_pec_top_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .rx_active_i, .tx_active_i, .full_duplex_flag_i, .ten_link_i, .crs_o,
  .ten_li_dis_o, .far_end_lb_o, .cable_lb_o, .edge_rate_o, .jumbo_sel_o, .max_pkt_len_o);
